// ---- verilog/aad_defs.svh ----
// address attribute decode: offsets, field positions, reset values
// assumes inclusion by bare name from the package and the top module
// Contract
// [RQ1] y data accesses compare address only when y enable bit 5 set
// [RQ2] x data accesses compare address only when x enable bit 4 set
// [RQ3] program accesses compare address only when program enable bit 3 set
// [RQ4] polarity bit 2: clear gives active low output, set active high
// [RQ5] access type bits 1..0: 01 sram, 10 dram, 00 and 11 reserved
// [RQ6] type 10 makes the output a row strobe, else plain attribute
// [RQ7] accesses matching no region always run as sram accesses
// [RQ8] software sets every access type field to 01 or 10 before use
// [RQ9] reset clears access type, space enables and polarity to zero
// [RQ10] twelve bit compare field matches upper address bits
// [RQ11] four bit count sets compared bits; zero means whole external space
// [RQ12] each register drives its own output, asserted only on a match
// [RQ13] all six control bits read back the last value written
`ifndef AAD_DEFS_SVH
`define AAD_DEFS_SVH
// =====================================================================
// register map
`define AAD_ATTR0_OFF 8'h00
`define AAD_STATUS_OFF 8'h10
`define AAD_REG_RESET 24'h00_0000
// =====================================================================
// fields
`define AAD_TYPE_LSB 0
`define AAD_POL_BIT 2
`define AAD_PEN_BIT 3
`define AAD_XEN_BIT 4
`define AAD_YEN_BIT 5
`define AAD_CNT_LSB 8
`define AAD_CMP_LSB 12
`define AAD_WMASK 24'hff_ff3f
`define AAD_CNT_MAX 4'hc
`define AAD_TYPE_SRAM 2'h1
`define AAD_TYPE_DRAM 2'h2
`define AAD_RESP_OKAY 2'h0
`define AAD_RESP_SLVERR 2'h2
`endif

// ---- verilog/aad_pkg.sv ----
// address attribute decode: shared types
// assumes the defs header sits in the include path
`include "aad_defs.svh"
package aad_pkg;
  // =====================================================================
  // core access carrier
  typedef enum logic [1:0] {AAD_SP_NONE, AAD_SP_PROG, AAD_SP_X, AAD_SP_Y}
    aad_space_t;
  typedef struct packed {
    logic valid;
    aad_space_t space;
    logic [23:0] addr;
    logic internal;
  } aad_access_t;
endpackage : aad_pkg

// ---- verilog/aad_top.sv ----
// address attribute decode: registers over axi4-lite and output decode
// assumes one clock, synchronous active low reset, synchronous inputs
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "aad_defs.svh"
module aad_top
  import aad_pkg::*;
#(
  parameter int NUM_REGS = 4,
  parameter int ADDR_W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire aad_access_t core_access,
  output logic [NUM_REGS-1:0] attribute_or_row_strobe_pin,
  output logic [NUM_REGS-1:0] row_strobe_mode,
  output logic access_is_dram
);

  // =====================================================================
  // elaboration check
  if (NUM_REGS < 1 || NUM_REGS > 4 || ADDR_W < 5)
  begin : g_bad_params
    $error("aad_top: NUM_REGS must be 1..4 and ADDR_W at least 5");
  end

  // =====================================================================
  // decode functions
  function automatic int reg_index(input logic [ADDR_W-1:0] a);
    int idx;
    idx = -1;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (a[ADDR_W-1:2] == (ADDR_W-2)'((`AAD_ATTR0_OFF + 4 * i) >> 2))
      begin
        idx = i;
      end
    end
    return idx;
  endfunction : reg_index

  function automatic logic region_hit(input logic [23:0] r,
                                      input aad_access_t a);
    logic en;
    logic [3:0] n;
    logic [11:0] m;
    en = (a.space == AAD_SP_PROG && r[`AAD_PEN_BIT]) // RQ3
      || (a.space == AAD_SP_X && r[`AAD_XEN_BIT]) // RQ2
      || (a.space == AAD_SP_Y && r[`AAD_YEN_BIT]); // RQ1
    n = r[`AAD_CNT_LSB+:4];
    if (n > `AAD_CNT_MAX)
    begin
      n = `AAD_CNT_MAX;
    end
    m = ~(12'hfff >> n); // RQ11
    return a.valid && en
      && (((a.addr[23:12] ^ r[`AAD_CMP_LSB+:12]) & m) == 12'h000) // RQ10
      && (n != 4'h0 || !a.internal); // RQ11
  endfunction : region_hit

  // =====================================================================
  // register and bus state
  logic [23:0] regs_q [NUM_REGS];
  logic [23:0] regs_d [NUM_REGS];
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [NUM_REGS-1:0] hit_q, hit_d, pin_q, pin_d, ras_q, ras_d;
  logic dram_q, dram_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

  always_comb
  begin
    int wi;
    int ri;
    logic [23:0] bmask;
    wi = reg_index(awaddr_q);
    ri = reg_index(s_axi_araddr);
    bmask = 24'h00_0000;
    regs_d = regs_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (aw_held_q && w_held_q && !bvalid_q)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wi >= 0) ? `AAD_RESP_OKAY : `AAD_RESP_SLVERR;
      for (int b = 0; b < 3; b++)
      begin
        bmask[8*b+:8] = {8{wstrb_q[b]}};
      end
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (wi == i)
        begin
          regs_d[i] = ((regs_q[i] & ~bmask)
            | (wdata_q[23:0] & bmask)) & `AAD_WMASK; // RQ13
        end
      end
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = `AAD_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (ri >= 0)
      begin
        for (int i = 0; i < NUM_REGS; i++)
        begin
          if (ri == i)
          begin
            rdata_d = {8'h00, regs_q[i]}; // RQ13
          end
        end
      end
      else if (s_axi_araddr[ADDR_W-1:2]
        == (ADDR_W-2)'(`AAD_STATUS_OFF >> 2))
      begin
        rdata_d = {23'h00_0000, dram_q, 4'(hit_q), 4'(ras_q)};
      end
      else
      begin
        rresp_d = `AAD_RESP_SLVERR;
      end
    end
    // ready outputs kept in their own flops
    awready_d = !aw_held_d;
    wready_d = !w_held_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_q[i] <= `AAD_REG_RESET; // RQ9
      end
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `AAD_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `AAD_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
    end
    else if (ce)
    begin
      regs_q <= regs_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  // =====================================================================
  // attribute output decode
  always_comb
  begin
    logic found;
    found = 1'b0;
    dram_d = 1'b0; // RQ7
    for (int i = 0; i < NUM_REGS; i++)
    begin
      hit_d[i] = region_hit(regs_q[i], core_access); // RQ12
      pin_d[i] = hit_d[i] ~^ regs_q[i][`AAD_POL_BIT]; // RQ4
      ras_d[i] = regs_q[i][`AAD_TYPE_LSB+:2] == `AAD_TYPE_DRAM; // RQ6
      if (hit_d[i] && !found)
      begin
        found = 1'b1;
        dram_d = ras_d[i]; // RQ5
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hit_q <= '0;
      pin_q <= '1;
      ras_q <= '0;
      dram_q <= 1'b0;
    end
    else if (ce)
    begin
      hit_q <= hit_d;
      pin_q <= pin_d;
      ras_q <= ras_d;
      dram_q <= dram_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign attribute_or_row_strobe_pin = pin_q;
  assign row_strobe_mode = ras_q;
  assign access_is_dram = dram_q;

  // =====================================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [23:0] r0;
  assign r0 = regs_q[0];

  sequence s_y_off;
    ce && core_access.valid && core_access.space == AAD_SP_Y
      && !r0[`AAD_YEN_BIT];
  endsequence
  sequence s_x_off;
    ce && core_access.valid && core_access.space == AAD_SP_X
      && !r0[`AAD_XEN_BIT];
  endsequence
  sequence s_p_off;
    ce && core_access.valid && core_access.space == AAD_SP_PROG
      && !r0[`AAD_PEN_BIT];
  endsequence

  a_yspace_gate: assert property (s_y_off |=> !hit_q[0]) // RQ1
    else $error("y access hit with y compare disabled");
  a_xspace_gate: assert property (s_x_off |=> !hit_q[0]) // RQ2
    else $error("x access hit with x compare disabled");
  a_pspace_gate: assert property (s_p_off |=> !hit_q[0]) // RQ3
    else $error("program access hit with program compare disabled");
  a_pin_polarity: assert property (ce |=> // RQ4
      pin_q[0] == (hit_q[0] ~^ $past(r0[`AAD_POL_BIT])))
    else $error("output level disagrees with polarity");
  a_default_sram: assert property (ce && !(|hit_d) |=> !dram_q) // RQ7
    else $error("unmatched access not treated as sram");
  a_dram_type: assert property (ce && hit_d[0] // RQ5
      && r0[1:0] == `AAD_TYPE_DRAM |=> dram_q)
    else $error("region 0 dram type not reported");
  a_ras_mode: assert property (ce |=> // RQ6
      row_strobe_mode[0] == ($past(r0[1:0]) == `AAD_TYPE_DRAM))
    else $error("row strobe mode mismatch");
  a_count_zero: assert property (ce && core_access.internal // RQ11
      && r0[`AAD_CNT_LSB+:4] == 4'h0 |=> !hit_q[0])
    else $error("count zero asserted on internal address");
  a_idle_deassert: assert property (ce && !core_access.valid // RQ12
      |=> hit_q == '0)
    else $error("output asserted without an access");
  a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> r0 == `AAD_REG_RESET) // RQ9
    else $error("register not cleared by reset");
  a_write_back: assert property (ce && aw_held_q && w_held_q // RQ13
      && ce
      && !bvalid_q && reg_index(awaddr_q) == 0 && wstrb_q[2:0] == 3'h7
      |=> r0 == ($past(wdata_q[23:0]) & `AAD_WMASK))
    else $error("register does not hold written value");

endmodule : aad_top

// ---- verif/aad_mem_model.sv ----
// external memory select model driven by the attribute pins
// assumes the bench tells it the asserted level of each pin
module aad_mem_model
(
  input wire logic [3:0] strobe_pin,
  input wire logic [3:0] active_high,
  output logic [3:0] chip_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // selected while the pin sits at its asserted level
  assign chip_sel = ~(strobe_pin ^ active_high);
endmodule : aad_mem_model

// ---- verif/address_attribute_decode_test.sv ----
// self-checking bench for the address attribute decode
// assumes the design asserts its own timing rules internally
module address_attribute_decode_test
  import aad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic ce = 1'b1;
  aad_access_t acc = '0;
  logic [3:0] act = '0;
  logic awready, wready, bvalid, arready, rvalid, dram;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] pins, rsm, sel;
  int err_total = 0;
  int check_count = 0;
  // =====================================================================
  // design and far side
  aad_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_access(acc),
    .attribute_or_row_strobe_pin(pins), .row_strobe_mode(rsm),
    .access_is_dram(dram));
  aad_mem_model mem_u (.strobe_pin(pins), .active_high(act),
    .chip_sel(sel));
  // =====================================================================
  // helpers
  task automatic summarize();
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] rv(input logic [11:0] c,
    input logic [3:0] n, input logic [2:0] en, input logic p,
    input logic [1:0] t);
    return {8'h00, c, n, 2'b00, en, p, t};
  endfunction : rv
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 0;
    while (!b_ok)
    begin
      @(negedge aclk);
      aw_ok = awready;
      w_ok = wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ar_ok, r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 0;
    while (!r_ok)
    begin
      @(negedge aclk);
      ar_ok = arready;
      r_ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd
  task automatic acs(input logic [1:0] s, input logic [23:0] ad,
    input logic inr);
    @(posedge aclk);
    acc <= '{1'b1, aad_space_t'(s), ad, inr};
    @(posedge aclk);
    acc <= '0;
    #1;
  endtask : acs
  // =====================================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk({rsm, dram, pins}, 32'h0000_000f);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i), d, r);
      chk(d, 32'h0000_0000);
      wr(8'(4 * i), rv(12'h000, 4'h1, 3'b000, 1'b0, 2'h1), r);
    end
  endtask : t_reset
  task automatic t_rw();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h08, 32'hffff_ffff, r);
    rd(8'h08, d, r);
    chk(d, 32'h00ff_ff3f);
    wr(8'h08, rv(12'h000, 4'h1, 3'b000, 1'b0, 2'h1), r);
    wr(8'h40, 32'h0000_0001, r);
    chk(r, 32'h0000_0002);
    rd(8'h40, d, r);
    chk({d[29:0], r}, 32'h0000_0002);
  endtask : t_rw
  task automatic t_space();
    logic [1:0] r;
    logic h;
    act = 4'h1;
    for (int e = 0; e < 3; e++)
    begin
      wr(8'h00, rv(12'habc, 4'hc, 3'(1 << e), 1'b1, 2'h1), r);
      for (int s = 1; s < 4; s++)
      begin
        acs(2'(s), 24'habc_123, 1'b0);
        h = (s == e + 1);
        chk({sel, pins}, {27'h0, h, 3'b111, h});
      end
    end
    acs(2'h3, 24'habd_000, 1'b0);
    chk(pins, 32'h0000_000e);
    act = 4'h0;
  endtask : t_space
  task automatic t_type();
    logic [1:0] r;
    logic m;
    for (int t = 1; t < 3; t++)
    begin
      wr(8'h00, rv(12'habc, 4'hc, 3'b001, 1'b0, 2'(t)), r);
      acs(2'h1, 24'habc_000, 1'b0);
      m = (t == 2);
      chk({rsm, dram, pins}, {27'h0, m, m, 4'he});
      acs(2'h1, 24'h123_000, 1'b0);
      chk({dram, pins}, 32'h0000_000f);
    end
  endtask : t_type
  task automatic t_count();
    logic [1:0] r;
    wr(8'h00, rv(12'h800, 4'h1, 3'b001, 1'b1, 2'h1), r);
    acs(2'h1, 24'h900_000, 1'b0);
    chk(pins, 32'h0000_000f);
    acs(2'h1, 24'h7ff_000, 1'b0);
    chk(pins, 32'h0000_000e);
    wr(8'h00, rv(12'h800, 4'h0, 3'b001, 1'b1, 2'h1), r);
    acs(2'h1, 24'h000_010, 1'b1);
    chk(pins, 32'h0000_000e);
    acs(2'h1, 24'h000_010, 1'b0);
    chk(pins, 32'h0000_000f);
  endtask : t_count
  task automatic t_freeze();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h00, rv(12'habc, 4'hc, 3'b001, 1'b0, 2'h2), r);
    chk(r, 32'h0000_0000);
    @(posedge aclk);
    ce <= 1'b0;
    acs(2'h1, 24'habc_000, 1'b0);
    chk({rsm, dram, pins}, 32'h0000_002f);
    @(posedge aclk);
    ce <= 1'b1;
    acs(2'h1, 24'habc_000, 1'b0);
    chk({rsm, dram, pins}, 32'h0000_003e);
    rd(8'h10, d, r);
    chk({d[29:0], r}, 32'h0000_0004);
  endtask : t_freeze
  // =====================================================================
  // run
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  initial
  begin
    #100000;
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    t_reset();
    t_rw();
    t_space();
    t_type();
    t_freeze();
    t_count();
    summarize();
  end
endmodule : address_attribute_decode_test
